// File: rtl/switch_inputs_pkg.sv
/*
 * Constants and types shared by the external switch input logic.
 * Assumes a single ref_clk domain at 25 MHz and a synchronous reset.
 */
// Summary of operation
// R1: Program pin selects set only when setting zero
// R2: Pin high selects set one, low set two
// R3: Program pin also usable as condition source
// R4: Timeout setting picks level or edge mode
// R5: Level mode: low sets flag, high clears
// R6: Edge mode: falling edge sets announcement flag
// R7: Edge mode: flag clears after timeout elapses
// R8: Edge mode: optional rising edge clears early
// R9: Other-network flag always level controlled
// R10: Programme flag and enable choose switch target
// R11: Both pins pass two-stage synchroniser first
package switch_inputs_pkg;
    localparam int unsigned CLK_HZ          = 25_000_000;
    localparam int unsigned TICK_US         = 1_000_000;
    localparam int unsigned TICK_CYCLES     = CLK_HZ / TICK_US * 1;
    // One timeout unit is one second
    localparam int unsigned UNIT_S          = 1;
    localparam int unsigned UNIT_CYCLES     = CLK_HZ * UNIT_S;
    localparam int unsigned TIMEOUT_W       = 8;
    localparam logic [1:0]  PROG_EXTERNAL   = 2'h0;
    localparam logic [1:0]  PROG_SET_ONE    = 2'h1;
    localparam logic [1:0]  PROG_SET_TWO    = 2'h2;
    localparam logic        LEVEL_ACTIVE    = 1'h0;

    typedef enum logic [2:0] {
        TA_IDLE   = 3'h1,
        TA_TIMED  = 3'h2,
        TA_LEVEL  = 3'h4
    } ta_state_t;
endpackage

// File: rtl/pin_sync.sv
/*
 * Two-stage synchroniser for one asynchronous pin.
 * Assumes the pin is a slow switch level; no debounce is done here.
 */
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
    input  wire logic ref_clk,
    input  wire logic reset,
    input  wire logic pin,
    output logic      level
);
    logic stage;

    // First stage is read only by the second [R11]
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            stage <= 1'h1;
            level <= 1'h1;
        end else begin
            stage <= pin;
            level <= stage;
        end
    end
endmodule
`default_nettype wire

// File: rtl/external_switch_inputs.sv
/*
 * External program set switch and traffic announcement switch.
 * Assumes raw pins from a switch or digital output; settings come from
 * same-clock logic and need no synchronising.
 */
`timescale 1ns/10ps
`default_nettype none
module external_switch_inputs
    import switch_inputs_pkg::*;
#(
    parameter int unsigned UNIT_COUNT = UNIT_CYCLES
) (
    input  wire logic                 ref_clk,
    input  wire logic                 reset,
    input  wire logic                 program_pin,
    input  wire logic                 traffic_pin,
    input  wire logic [1:0]           program_setting,
    input  wire logic                 cond_source_enable,
    input  wire logic [TIMEOUT_W-1:0] announce_timeout,
    input  wire logic                 rising_release_enable,
    input  wire logic                 local_traffic_programme,
    input  wire logic                 other_net_one_enable,
    output logic                      program_set_two,
    output logic                      condition_level,
    output logic                      traffic_announce,
    output logic                      other_net_one_traffic_flag,
    output logic                      switch_disabled
);
    // A zero unit length would never finish a timeout unit
    if (UNIT_COUNT < 1) begin : g_bad_unit
        $error("UNIT_COUNT must be at least one");
    end

    logic prog_sync;
    logic ta_sync;
    logic ta_prev;
    logic [31:0] unit_cnt;
    logic [TIMEOUT_W-1:0] units_left;
    ta_state_t state;
    ta_state_t next_state;

    pin_sync u_prog_sync (
        .ref_clk (ref_clk),
        .reset   (reset),
        .pin     (program_pin),
        .level   (prog_sync)
    );

    pin_sync u_ta_sync (
        .ref_clk (ref_clk),
        .reset   (reset),
        .pin     (traffic_pin),
        .level   (ta_sync)
    );

    // Target decode of the traffic switch
    wire drive_ta     = local_traffic_programme;                        // [R10]
    wire drive_eon    = !local_traffic_programme && other_net_one_enable; // [R10]
    wire sw_off       = !local_traffic_programme && !other_net_one_enable; // [R10]
    wire edge_mode    = (announce_timeout != '0);                       // [R4]
    wire pin_active   = (ta_sync == LEVEL_ACTIVE);
    wire falling      = ta_prev && !ta_sync;                            // [R6]
    wire rising       = !ta_prev && ta_sync;                            // [R8]
    wire unit_done    = (unit_cnt == UNIT_COUNT - 1);
    wire timed_out    = unit_done && (units_left == TIMEOUT_W'(1));     // [R7]

    // Program selection; pin ignored unless setting is zero
    wire prog_ext     = (program_setting == PROG_EXTERNAL) && !cond_source_enable; // [R1] [R3]
    wire next_set_two = prog_ext ? (prog_sync == LEVEL_ACTIVE)          // [R2]
                                 : (program_setting == PROG_SET_TWO);

    always_comb begin
        next_state = state;
        unique case (state)
            TA_IDLE: begin
                if (drive_ta && !edge_mode) begin
                    next_state = TA_LEVEL;
                end else if (drive_ta && falling) begin
                    next_state = TA_TIMED;                              // [R6]
                end
            end
            TA_TIMED: begin
                if (!drive_ta || !edge_mode) begin
                    next_state = TA_IDLE;
                end else if (timed_out || (rising_release_enable && rising)) begin
                    next_state = TA_IDLE;                               // [R7] [R8]
                end
            end
            TA_LEVEL: begin
                if (!drive_ta || edge_mode) begin
                    next_state = TA_IDLE;
                end
            end
            default: next_state = TA_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state <= TA_IDLE;
            ta_prev <= 1'h1;
        end else begin
            state <= next_state;
            ta_prev <= ta_sync;
        end
    end

    // Timeout counter restarts on every activation
    always_ff @(posedge ref_clk) begin
        if (reset || state != TA_TIMED) begin
            unit_cnt <= '0;
            units_left <= announce_timeout;
        end else if (unit_done) begin
            unit_cnt <= '0;
            units_left <= units_left - TIMEOUT_W'(1);
        end else begin
            unit_cnt <= unit_cnt + 32'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            program_set_two <= 1'h0;
            condition_level <= 1'h1;
            traffic_announce <= 1'h0;
            other_net_one_traffic_flag <= 1'h0;
            switch_disabled <= 1'h0;
        end else begin
            program_set_two <= next_set_two;
            condition_level <= prog_sync;                               // [R3]
            traffic_announce <= (next_state == TA_TIMED)
                             || (next_state == TA_LEVEL && pin_active); // [R5]
            other_net_one_traffic_flag <= drive_eon && pin_active;      // [R9]
            switch_disabled <= sw_off;
        end
    end

    property p_level_ta;
        @(posedge ref_clk) disable iff (reset)
        (state == TA_LEVEL && next_state == TA_LEVEL) |=> (traffic_announce == $past(pin_active));
    endproperty
    a_level_ta: assert property (p_level_ta) else $error("level mode flag wrong"); // [R5]

    sequence s_fall_edge;
        drive_ta && edge_mode && falling && state == TA_IDLE;
    endsequence
    property p_edge_set;
        @(posedge ref_clk) disable iff (reset)
        s_fall_edge |=> traffic_announce;
    endproperty
    a_edge_set: assert property (p_edge_set) else $error("edge did not set flag"); // [R6]

    property p_timeout_clear;
        @(posedge ref_clk) disable iff (reset)
        (state == TA_TIMED && timed_out) |=> !traffic_announce;
    endproperty
    a_timeout_clear: assert property (p_timeout_clear) else $error("timeout kept flag"); // [R7]

    property p_rise_clear;
        @(posedge ref_clk) disable iff (reset)
        (state == TA_TIMED && rising_release_enable && rising) |=> !traffic_announce;
    endproperty
    a_rise_clear: assert property (p_rise_clear) else $error("rise kept flag"); // [R8]

    property p_eon_level;
        @(posedge ref_clk) disable iff (reset)
        drive_eon |=> (other_net_one_traffic_flag == $past(pin_active));
    endproperty
    a_eon_level: assert property (p_eon_level) else $error("eon flag wrong"); // [R9]

    property p_disabled;
        @(posedge ref_clk) disable iff (reset)
        sw_off ##1 sw_off |=> !traffic_announce && !other_net_one_traffic_flag;
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled switch drove flag"); // [R10]

    property p_prog_ext;
        @(posedge ref_clk) disable iff (reset)
        prog_ext |=> (program_set_two == ($past(prog_sync) == LEVEL_ACTIVE));
    endproperty
    a_prog_ext: assert property (p_prog_ext) else $error("program pin not followed"); // [R2]

    property p_prog_fixed;
        @(posedge ref_clk) disable iff (reset)
        (program_setting == PROG_SET_ONE) |=> !program_set_two;
    endproperty
    a_prog_fixed: assert property (p_prog_fixed) else $error("pin overrode setting"); // [R1]

    property p_sync_delay;
        @(posedge ref_clk) disable iff (reset)
        $fell(ta_sync) |-> $past(traffic_pin, 2) == 1'h0;
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("sync depth wrong"); // [R11]

    property p_mode;
        @(posedge ref_clk) disable iff (reset)
        edge_mode |=> state != TA_LEVEL || $past(state) == TA_LEVEL;
    endproperty
    a_mode: assert property (p_mode) else $error("level mode entered in edge mode"); // [R4]

    // Timed announcement steps: entry loads the timer, then holds until release
    sequence s_enter_timed;
        state == TA_IDLE ##1 state == TA_TIMED;
    endsequence

    sequence s_hold_timed;
        state == TA_TIMED && drive_ta && edge_mode && !timed_out;
    endsequence

    property p_timer_load;
        @(posedge ref_clk) disable iff (reset)
        s_enter_timed |-> units_left == $past(announce_timeout) && unit_cnt == 32'h0;
    endproperty
    a_timer_load: assert property (p_timer_load) else $error("timer not loaded"); // [R7]

    property p_timed_holds;
        @(posedge ref_clk) disable iff (reset)
        s_hold_timed ##0 !(rising_release_enable && rising) |=> traffic_announce;
    endproperty
    a_timed_holds: assert property (p_timed_holds) else $error("flag dropped early"); // [R7]

    property p_rise_ignored;
        @(posedge ref_clk) disable iff (reset)
        s_hold_timed ##0 (rising && !rising_release_enable) |=> traffic_announce;
    endproperty
    a_rise_ignored: assert property (p_rise_ignored) else $error("rise cleared flag"); // [R8]

    // No retrigger: a second fall while timed must not restart anything
    property p_no_retrigger;
        @(posedge ref_clk) disable iff (reset)
        s_hold_timed ##0 falling |=> state == TA_TIMED;
    endproperty
    a_no_retrigger: assert property (p_no_retrigger) else $error("fall left timed state"); // [R6]

    property p_level_exit;
        @(posedge ref_clk) disable iff (reset)
        (state == TA_LEVEL && edge_mode) |=> state == TA_IDLE;
    endproperty
    a_level_exit: assert property (p_level_exit) else $error("level kept in edge mode"); // [R4]

    property p_idle_no_flag;
        @(posedge ref_clk) disable iff (reset)
        (state == TA_IDLE && next_state == TA_IDLE) |=> !traffic_announce;
    endproperty
    a_idle_no_flag: assert property (p_idle_no_flag) else $error("flag set while idle"); // [R6]

    property p_ta_target;
        @(posedge ref_clk) disable iff (reset)
        !drive_ta |=> !traffic_announce;
    endproperty
    a_ta_target: assert property (p_ta_target) else $error("flag set off target"); // [R10]

    property p_eon_target;
        @(posedge ref_clk) disable iff (reset)
        drive_ta |=> !other_net_one_traffic_flag;
    endproperty
    a_eon_target: assert property (p_eon_target) else $error("eon set off target"); // [R10]

    property p_disabled_out;
        @(posedge ref_clk) disable iff (reset)
        sw_off |=> switch_disabled;
    endproperty
    a_disabled_out: assert property (p_disabled_out) else $error("disable not shown"); // [R10]

    property p_enabled_out;
        @(posedge ref_clk) disable iff (reset)
        !sw_off |=> !switch_disabled;
    endproperty
    a_enabled_out: assert property (p_enabled_out) else $error("disable shown wrongly"); // [R10]

    property p_cond_level;
        @(posedge ref_clk) disable iff (reset)
        1'b1 |=> condition_level == $past(prog_sync);
    endproperty
    a_cond_level: assert property (p_cond_level) else $error("condition level wrong"); // [R3]

    // Condition use frees program selection back to the setting
    property p_prog_cond;
        @(posedge ref_clk) disable iff (reset)
        cond_source_enable |=> program_set_two == ($past(program_setting) == PROG_SET_TWO);
    endproperty
    a_prog_cond: assert property (p_prog_cond) else $error("pin used while condition"); // [R3]

    property p_prog_sync;
        @(posedge ref_clk) disable iff (reset)
        $changed(prog_sync) |-> prog_sync == $past(program_pin, 2);
    endproperty
    a_prog_sync: assert property (p_prog_sync) else $error("program sync depth wrong"); // [R11]

    property p_onehot;
        @(posedge ref_clk) disable iff (reset)
        1'b1 |-> $onehot(state);
    endproperty
    a_onehot: assert property (p_onehot) else $error("state code illegal"); // [R4]

    property p_units_bound;
        @(posedge ref_clk) disable iff (reset)
        state == TA_TIMED |-> units_left != TIMEOUT_W'(0);
    endproperty
    a_units_bound: assert property (p_units_bound) else $error("timer ran past zero"); // [R7]

    property p_cnt_bound;
        @(posedge ref_clk) disable iff (reset)
        1'b1 |-> unit_cnt < UNIT_COUNT;
    endproperty
    a_cnt_bound: assert property (p_cnt_bound) else $error("unit counter overran"); // [R7]
endmodule
`default_nettype wire

// File: sim/switch_model.sv
/*
 * Model of the external switches wired to the program and traffic pins.
 * Assumes the bench commands each contact as closed or open.
 */
`timescale 1ns/10ps
`default_nettype none
module switch_model (
    input  wire logic prog_closed,
    input  wire logic traffic_closed,
    output logic      program_pin,
    output logic      traffic_pin
);
    // Driven contacts, so an open switch shows a firm high, never a float
    assign program_pin = ~prog_closed;
    assign traffic_pin = ~traffic_closed;
endmodule
`default_nettype wire

// File: sim/testbench.sv
/*
 * Self-checking bench for the external switch inputs.
 * Assumes UNIT_COUNT of 4, so one timeout unit lasts 4 clocks.
 */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import switch_inputs_pkg::*;
    logic       ref_clk, reset, prog_closed, traffic_closed, cond_en, rise_en, tp, eon_en;
    logic [1:0] prog_setting;
    logic [7:0] tmout;
    wire        program_pin, traffic_pin, set_two, cond_lvl, ta, eon_ta, sw_dis;
    int         n_fail, tests_run;

    switch_model switch_model_inst (.prog_closed(prog_closed),
        .traffic_closed(traffic_closed), .program_pin(program_pin),
        .traffic_pin(traffic_pin));
    external_switch_inputs #(.UNIT_COUNT(4)) external_switch_inputs_inst (
        .ref_clk(ref_clk), .reset(reset), .program_pin(program_pin),
        .traffic_pin(traffic_pin), .program_setting(prog_setting),
        .cond_source_enable(cond_en), .announce_timeout(tmout),
        .rising_release_enable(rise_en), .local_traffic_programme(tp),
        .other_net_one_enable(eon_en), .program_set_two(set_two),
        .condition_level(cond_lvl), .traffic_announce(ta),
        .other_net_one_traffic_flag(eon_ta), .switch_disabled(sw_dis));

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(input logic got, input logic exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask
    task automatic finish_test;
        $display("counts: %0d compared, %0d failed", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic t_program;
        prog_setting = 2'h0; prog_closed = 1'b0; step(6);
        chk(set_two, 1'b0, "open pin");
        prog_closed = 1'b1; step(6);
        chk(set_two, 1'b1, "closed pin");
        chk(cond_lvl, 1'b0, "cond low");
        prog_setting = 2'h1; step(3);
        chk(set_two, 1'b0, "fixed set one");
        prog_setting = 2'h2; prog_closed = 1'b0; step(6);
        chk(set_two, 1'b1, "fixed set two");
        chk(cond_lvl, 1'b1, "cond high");
        prog_setting = 2'h0; cond_en = 1'b1; prog_closed = 1'b1; step(6);
        chk(cond_lvl, 1'b0, "cond source");
        chk(set_two, 1'b0, "cond ignores pin");
        cond_en = 1'b0; prog_closed = 1'b0; step(6);
        $display("test program done");
    endtask
    task automatic t_level;
        tp = 1'b1; tmout = 8'h00; traffic_closed = 1'b1; step(2);
        chk(ta, 1'b0, "too early");
        step(3);
        chk(ta, 1'b1, "level on");
        step(20);
        chk(ta, 1'b1, "level holds");
        traffic_closed = 1'b0; step(5);
        chk(ta, 1'b0, "level off");
        $display("test level done");
    endtask
    task automatic t_edge(input logic early);
        tmout = 8'h02; rise_en = early; traffic_closed = 1'b1; step(6);
        chk(ta, 1'b1, "edge on");
        if (early) begin
            traffic_closed = 1'b0; step(3);
            chk(ta, 1'b0, "early release");
            step(3);
        end else begin
            step(14);
            chk(ta, 1'b0, "timed release");
            traffic_closed = 1'b0; step(6);
        end
        rise_en = 1'b0;
        $display("test edge done");
    endtask
    task automatic t_eon;
        tp = 1'b0; eon_en = 1'b1; tmout = 8'h01; traffic_closed = 1'b1; step(6);
        chk(eon_ta, 1'b1, "eon on");
        chk(ta, 1'b0, "ta idle");
        step(20);
        chk(eon_ta, 1'b1, "eon level");
        traffic_closed = 1'b0; step(5);
        chk(eon_ta, 1'b0, "eon off");
        eon_en = 1'b0; traffic_closed = 1'b1; step(6);
        chk(sw_dis, 1'b1, "disabled");
        chk(eon_ta | ta, 1'b0, "no target");
        $display("test eon done");
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    initial begin
        #300000;
        n_fail++;
        finish_test();
    end
    initial begin
        n_fail = 0; tests_run = 0; reset = 1'b1; prog_closed = 1'b0;
        traffic_closed = 1'b0; cond_en = 1'b0; rise_en = 1'b0; tp = 1'b0;
        eon_en = 1'b0; prog_setting = 2'h0; tmout = 8'h00;
        step(12);
        reset = 1'b0;
        t_program();
        t_level();
        t_edge(1'b0);
        t_edge(1'b1);
        t_eon();
        finish_test();
    end
endmodule
`default_nettype wire
